// file: rtl/cwc_top.sv
`timescale 1ns/100ps
module cwc_top
    import cwc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic power_on_reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic internal_fast_oscillator,
    input wire logic logic_cell_one_output,
    input wire logic oscillator_unit_output,
    input wire logic pulse_unit_one_output,
    input wire logic pulse_unit_two_output,
    input wire logic pulse_unit_three_output,
    input wire logic pulse_unit_four_output,
    input wire logic comparator_one_raw_output,
    input wire logic comparator_two_raw_output,
    input wire logic logic_cell_two_output,
    input wire logic external_fault_input,
    output logic waveform_output_a,
    output logic waveform_output_a_oe,
    output logic waveform_output_b,
    output logic waveform_output_b_oe
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] addr_idx(input logic [7:0] a);
        logic [2:0] r;
        r = CWC_IDX_NONE;
        case (a)
            CWC_OFF_MAIN: r = CWC_IDX_MAIN;
            CWC_OFF_SEL: r = CWC_IDX_SEL;
            CWC_OFF_AUTO: r = CWC_IDX_AUTO;
            CWC_OFF_DBR: r = CWC_IDX_DBR;
            CWC_OFF_DBF: r = CWC_IDX_DBF;
            default: r = CWC_IDX_NONE;
        endcase
        return r;
    endfunction

    // override decode shared by both channels
    function automatic logic chan_level(input logic [1:0] code, input logic shut,
                                        input logic norm);
        logic r;
        r = norm;
        if (shut) begin
            case (code)
                CWC_LVL_HIGH: r = 1'b1;
                CWC_LVL_LOW: r = 1'b0;
                CWC_LVL_TRI: r = 1'b0;
                default: r = norm;
            endcase
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic rst_all_n;
    logic [CWC_SRC_N-1:0] src_raw;
    logic [CWC_SRC_N-1:0] src_q;
    logic [7:0] wave_src;
    logic [7:0] main_r;
    logic [7:0] main_nxt;
    logic [6:0] auto_r;
    logic [6:0] auto_nxt;
    logic ase_r;
    logic ase_nxt;
    logic [2:0] sel_r;
    logic [2:0] sel_nxt;
    logic [3:0] lvl_r;
    logic [3:0] lvl_nxt;
    logic [5:0] dbr_r;
    logic [5:0] dbr_nxt;
    logic [5:0] dbf_r;
    logic [5:0] dbf_nxt;
    logic wr_pend_r;
    logic [2:0] wr_idx_r;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic hreadyout_r;
    logic acc;
    logic acc_wr;
    logic [2:0] acc_idx;
    logic wr_main;
    logic wr_sel;
    logic wr_auto;
    logic wr_dbr;
    logic wr_dbf;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic en;
    logic sd_src;
    logic shut_r;
    logic shut_nxt;
    logic in_sel;
    logic in_d_r;
    logic in_rise;
    logic hf_d_r;
    logic tick;
    logic run;
    logic a_on;
    logic b_on;
    logic a_val;
    logic b_val;
    logic out_a_r;
    logic out_b_r;
    logic oe_a_r;
    logic oe_b_r;
    logic out_a_nxt;
    logic out_b_nxt;
    logic oe_a_nxt;
    logic oe_b_nxt;

    // either reset clears the plain fields
    assign rst_all_n = hresetn & power_on_reset_n;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    assign src_raw = {internal_fast_oscillator, external_fault_input,
                      logic_cell_two_output, logic_cell_one_output,
                      oscillator_unit_output, pulse_unit_four_output,
                      pulse_unit_three_output, pulse_unit_two_output,
                      pulse_unit_one_output, comparator_one_raw_output,
                      comparator_two_raw_output};

    cwc_sync #(.WIDTH(CWC_SRC_N)) u_sync (
        .hclk(hclk),
        .rst_n(rst_all_n),
        .d(src_raw),
        .q(src_q)
    );

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    assign acc = hsel & (htrans == CWC_HTRANS_NONSEQ) & hready;
    assign acc_wr = acc & hwrite & (hsize == CWC_HSIZE_WORD);
    assign acc_idx = addr_idx(haddr[7:0]);
    assign wbyte = hwdata[7:0];
    assign wr_main = wr_pend_r & (wr_idx_r == CWC_IDX_MAIN);
    assign wr_sel = wr_pend_r & (wr_idx_r == CWC_IDX_SEL);
    assign wr_auto = wr_pend_r & (wr_idx_r == CWC_IDX_AUTO);
    assign wr_dbr = wr_pend_r & (wr_idx_r == CWC_IDX_DBR);
    assign wr_dbf = wr_pend_r & (wr_idx_r == CWC_IDX_DBF);

    // register next values, unimplemented bits masked off
    assign main_nxt = wr_main ? (wbyte & CWC_MAIN_MASK) : main_r;
    assign auto_nxt = wr_auto ? (wbyte[6:0] & CWC_AUTO_MASK[6:0]) : auto_r;
    assign sel_nxt = wr_sel ? wbyte[2:0] : sel_r;
    assign lvl_nxt = wr_sel ? wbyte[7:4] : lvl_r;
    assign dbr_nxt = wr_dbr ? wbyte[5:0] : dbr_r;
    assign dbf_nxt = wr_dbf ? wbyte[5:0] : dbf_r;

    // read data from next values, zeros elsewhere
    assign rd_byte = (acc_idx == CWC_IDX_MAIN) ? main_nxt :
                     (acc_idx == CWC_IDX_SEL) ? {lvl_nxt, 1'b0, sel_nxt} :
                     (acc_idx == CWC_IDX_AUTO) ? {ase_nxt, auto_nxt} :
                     (acc_idx == CWC_IDX_DBR) ? {2'b00, dbr_nxt} :
                     (acc_idx == CWC_IDX_DBF) ? {2'b00, dbf_nxt} : 8'h00;
    assign hrdata_nxt = (acc & ~hwrite) ? {24'h000000, rd_byte} : hrdata_r;

    // bus pipeline registers
    always_ff @(posedge hclk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= CWC_IDX_NONE;
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
        end else begin
            wr_pend_r <= acc_wr;
            wr_idx_r <= acc_idx;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= 1'b1;
        end
    end
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            main_r <= CWC_RST_MAIN;
            auto_r <= CWC_RST_AUTO;
            ase_r <= 1'b0;
            sel_r <= CWC_RST_IS;
        end else begin
            main_r <= main_nxt;
            auto_r <= auto_nxt;
            ase_r <= ase_nxt;
            sel_r <= sel_nxt;
        end
    end

    always_ff @(posedge hclk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            lvl_r <= CWC_POR_LVL;
            dbr_r <= CWC_POR_DB;
            dbf_r <= CWC_POR_DB;
        end else begin
            lvl_r <= lvl_nxt;
            dbr_r <= dbr_nxt;
            dbf_r <= dbf_nxt;
        end
    end

    // ------------------------------------------------------------
    // shutdown control
    // ------------------------------------------------------------
    // enabled sources ORed
    assign sd_src = (auto_r[CWC_AUTO_C2] & src_q[0]) |
                    (auto_r[CWC_AUTO_C1] & src_q[1]) |
                    (auto_r[CWC_AUTO_FLT] & ~src_q[9]) |
                    (auto_r[CWC_AUTO_LC2] & src_q[8]);
    // set wins, live source holds status
    // auto-restart clears once sources are low
    assign ase_nxt = sd_src |
                     (wr_auto ? wbyte[CWC_AUTO_ASE] :
                      (ase_r & ~auto_r[CWC_AUTO_ARS]));
    // overrides hold until first rising edge after clear
    assign shut_nxt = ase_nxt | (shut_r & ~(in_rise & ~ase_r));

    // ------------------------------------------------------------
    // waveform path
    // ------------------------------------------------------------
    // module enable gates edge detect, dead-band counters and pins
    assign en = main_r[CWC_MAIN_ON];
    assign wave_src = src_q[7:0];
    assign in_sel = wave_src[sel_r];
    assign in_rise = en & in_sel & ~in_d_r;
    // count on oscillator edges or every cycle
    assign tick = main_r[CWC_MAIN_CS] ? (src_q[10] & ~hf_d_r) : 1'b1;
    assign run = en & ~shut_nxt;

    // edge history and shutdown state
    always_ff @(posedge hclk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            in_d_r <= 1'b0;
            hf_d_r <= 1'b0;
            shut_r <= 1'b0;
        end else begin
            in_d_r <= in_sel;
            hf_d_r <= src_q[10];
            shut_r <= shut_nxt;
        end
    end

    // rising edge delays turn-on of A
    cwc_dead_band #(.WIDTH(CWC_DB_W)) u_rise (
        .hclk(hclk),
        .rst_n(rst_all_n),
        .level(run & in_sel),
        .tick(tick),
        .value(dbr_r),
        .on(a_on)
    );

    // falling edge delays turn-on of B
    cwc_dead_band #(.WIDTH(CWC_DB_W)) u_fall (
        .hclk(hclk),
        .rst_n(rst_all_n),
        .level(run & ~in_sel),
        .tick(tick),
        .value(dbf_r),
        .on(b_on)
    );

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    // polarity on normal level; overrides
    assign a_val = chan_level(lvl_r[1:0], shut_nxt, a_on ^ main_r[CWC_MAIN_POLA]);
    assign b_val = chan_level(lvl_r[3:2], shut_nxt, b_on ^ main_r[CWC_MAIN_POLB]);
    assign out_a_nxt = en & a_val;
    assign out_b_nxt = en & b_val;
    // pin enables, tri-state override drops drive
    assign oe_a_nxt = en & main_r[CWC_MAIN_OEA] & ~(shut_nxt & (lvl_r[1:0] == CWC_LVL_TRI));
    assign oe_b_nxt = en & main_r[CWC_MAIN_OEB] & ~(shut_nxt & (lvl_r[3:2] == CWC_LVL_TRI));

    // registered pins
    always_ff @(posedge hclk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
            oe_a_r <= 1'b0;
            oe_b_r <= 1'b0;
        end else begin
            out_a_r <= out_a_nxt;
            out_b_r <= out_b_nxt;
            oe_a_r <= oe_a_nxt;
            oe_b_r <= oe_b_nxt;
        end
    end
    assign waveform_output_a = out_a_r;
    assign waveform_output_b = out_b_r;
    assign waveform_output_a_oe = oe_a_r;
    assign waveform_output_b_oe = oe_b_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // disabled module drives no pin
    a_disabled_quiet: assert property (@(posedge hclk) disable iff (!rst_all_n)
        !en |=> (!oe_a_r && !oe_b_r && !out_a_r && !out_b_r))
        else $error("disabled module still drives");
    // pin enable low keeps A released
    a_pin_enable: assert property (@(posedge hclk) disable iff (!rst_all_n)
        !main_r[CWC_MAIN_OEA] |=> !oe_a_r)
        else $error("output A driven without enable");
    a_polarity_a: assert property (@(posedge hclk) disable iff (!rst_all_n)
        (en && !shut_nxt) |=> out_a_r == ($past(a_on) ^ $past(main_r[CWC_MAIN_POLA])))
        else $error("output A polarity wrong");
    // system clock select ticks every cycle
    a_tick_select: assert property (@(posedge hclk) disable iff (!rst_all_n)
        !main_r[CWC_MAIN_CS] |-> tick)
        else $error("tick missing on system clock");
    a_reserved_zero: assert property (@(posedge hclk) disable iff (!rst_all_n)
        (main_r[2:1] == 2'b00) && (auto_r[5:4] == 2'b00) && (hrdata_r[31:8] == 24'h0))
        else $error("reserved bits not zero");
    // forced high on B ignores polarity
    a_force_high_b: assert property (@(posedge hclk) disable iff (!rst_all_n)
        (en && shut_nxt && lvl_r[3:2] == CWC_LVL_HIGH) |=> out_b_r)
        else $error("output B override high missing");
    a_tristate_a: assert property (@(posedge hclk) disable iff (!rst_all_n)
        (shut_nxt && lvl_r[1:0] == CWC_LVL_TRI) |=> !oe_a_r)
        else $error("output A not released");
    // live source sets status next cycle
    a_status_set: assert property (@(posedge hclk) disable iff (!rst_all_n)
        sd_src |=> ase_r)
        else $error("shutdown status not set");
    // auto-restart clears status when sources low
    a_auto_clear: assert property (@(posedge hclk) disable iff (!rst_all_n)
        (ase_r && auto_r[CWC_AUTO_ARS] && !sd_src && !wr_auto) |=> !ase_r)
        else $error("auto-restart did not clear status");
    a_status_hold: assert property (@(posedge hclk) disable iff (!rst_all_n)
        (ase_r && !auto_r[CWC_AUTO_ARS] && !wr_auto) |=> ase_r)
        else $error("status cleared without software");
    // A and B are never both on
    a_no_overlap: assert property (@(posedge hclk) disable iff (!rst_all_n)
        !(a_on && b_on))
        else $error("both channels on together");

endmodule // cwc_top

// file: rtl/cwc_pkg.sv
package cwc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CWC_OFF_MAIN = 8'h00;
    localparam logic [7:0] CWC_OFF_SEL = 8'h04;
    localparam logic [7:0] CWC_OFF_AUTO = 8'h08;
    localparam logic [7:0] CWC_OFF_DBR = 8'h0C;
    localparam logic [7:0] CWC_OFF_DBF = 8'h10;

    // register indices used between address and data phase
    localparam logic [2:0] CWC_IDX_MAIN = 3'h0;
    localparam logic [2:0] CWC_IDX_SEL = 3'h1;
    localparam logic [2:0] CWC_IDX_AUTO = 3'h2;
    localparam logic [2:0] CWC_IDX_DBR = 3'h3;
    localparam logic [2:0] CWC_IDX_DBF = 3'h4;
    localparam logic [2:0] CWC_IDX_NONE = 3'h7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CWC_MAIN_ON = 7;
    localparam int CWC_MAIN_OEB = 6;
    localparam int CWC_MAIN_OEA = 5;
    localparam int CWC_MAIN_POLB = 4;
    localparam int CWC_MAIN_POLA = 3;
    localparam int CWC_MAIN_CS = 0;
    localparam int CWC_AUTO_ASE = 7;
    localparam int CWC_AUTO_ARS = 6;
    localparam int CWC_AUTO_C2 = 3;
    localparam int CWC_AUTO_C1 = 2;
    localparam int CWC_AUTO_FLT = 1;
    localparam int CWC_AUTO_LC2 = 0;

    // implemented-bit masks, reset values
    localparam logic [7:0] CWC_MAIN_MASK = 8'hF9;
    localparam logic [7:0] CWC_SEL_MASK = 8'hF7;
    localparam logic [7:0] CWC_AUTO_MASK = 8'hCF;
    localparam logic [7:0] CWC_DB_MASK = 8'h3F;
    localparam logic [7:0] CWC_RST_MAIN = 8'h00;
    localparam logic [6:0] CWC_RST_AUTO = 7'h00;
    localparam logic [2:0] CWC_RST_IS = 3'h0;
    localparam logic [3:0] CWC_POR_LVL = 4'h0;
    localparam logic [5:0] CWC_POR_DB = 6'h00;

    // shutdown override codes
    localparam logic [1:0] CWC_LVL_HIGH = 2'h3;
    localparam logic [1:0] CWC_LVL_LOW = 2'h2;
    localparam logic [1:0] CWC_LVL_TRI = 2'h1;
    localparam logic [1:0] CWC_LVL_INACT = 2'h0;

    // bus encodings and widths
    localparam logic [1:0] CWC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] CWC_HSIZE_WORD = 3'h2;
    localparam int CWC_DB_W = 6;
    localparam int CWC_SRC_N = 11;

endpackage

// file: rtl/cwc_sync.sv
`timescale 1ns/100ps
module cwc_sync
    import cwc_pkg::*;
#(
    parameter int WIDTH = CWC_SRC_N
) (
    input wire logic hclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ------------------------------------------------------------
    // two-stage synchroniser per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            // first stage feeds only the second
            always_ff @(posedge hclk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d[i];
                    sync_r <= meta_r;
                end
            end
            assign q[i] = sync_r;
        end
    endgenerate

endmodule // cwc_sync

// file: rtl/cwc_dead_band.sv
`timescale 1ns/100ps
module cwc_dead_band
    import cwc_pkg::*;
#(
    parameter int WIDTH = CWC_DB_W
) (
    input wire logic hclk,
    input wire logic rst_n,
    input wire logic level,
    input wire logic tick,
    input wire logic [WIDTH-1:0] value,
    output logic on
);

    logic level_d_r;
    logic busy_r;
    logic on_r;
    logic [WIDTH-1:0] cnt_r;
    logic rise;
    logic done;
    logic [WIDTH-1:0] cnt_inc;
    logic busy_nxt;
    logic on_nxt;
    logic [WIDTH-1:0] cnt_nxt;

    // ------------------------------------------------------------
    // delayed turn-on counter
    // ------------------------------------------------------------
    assign rise = level & ~level_d_r;
    assign cnt_inc = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
    assign done = busy_r & tick & (cnt_inc == value);
    // off at once, on after count
    assign on_nxt = level & (on_r | done | (rise & (value == '0)));
    assign busy_nxt = level & ((rise & (value != '0)) | (busy_r & ~done));
    assign cnt_nxt = rise ? '0 : ((busy_r & tick) ? cnt_inc : cnt_r);

    // state update
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            level_d_r <= 1'b0;
            busy_r <= 1'b0;
            on_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            level_d_r <= level;
            busy_r <= busy_nxt;
            on_r <= on_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign on = on_r;

    // zero count turns on next cycle
    a_zero_bypass: assert property (@(posedge hclk) disable iff (!rst_n)
        (rise && value == '0) |=> on_r)
        else $error("zero dead band did not pass through");
    a_off_at_once: assert property (@(posedge hclk) disable iff (!rst_n)
        !level |=> !on_r)
        else $error("output not turned off at once");
    a_delay_held: assert property (@(posedge hclk) disable iff (!rst_n)
        (rise && value != '0) |=> !on_r)
        else $error("output turned on before dead band");

endmodule // cwc_dead_band

// file: tb/cwc_switch_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// power switch gate drivers on the two outputs
// ------------------------------------------------------------
module cwc_switch_model (
    input wire logic hclk,
    input wire logic a,
    input wire logic a_oe,
    input wire logic b,
    input wire logic b_oe,
    output logic pin_a,
    output logic pin_b,
    output int shoot_cnt
);
    // released gate inputs sit on their pull-downs
    assign pin_a = a_oe ? a : 1'b0;
    assign pin_b = b_oe ? b : 1'b0;
    // count cycles with both switches on
    initial shoot_cnt = 0;
    always @(posedge hclk) begin
        if (pin_a && pin_b) begin
            shoot_cnt <= shoot_cnt + 1;
        end
    end
endmodule // cwc_switch_model

// file: tb/complementary_waveform_control_tb.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module complementary_waveform_control_tb
    import cwc_pkg::*;
;
    logic hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = '0;
    logic hreadyout, hresp, wa, wa_oe, wb, wb_oe, pin_a, pin_b, flt = 1, hfo = 0;
    logic [8:0] src = '0;
    int n_mismatch = 0, checks = 0, shoot, shoot_cnt, k;
    logic [7:0] off [5] = '{CWC_OFF_MAIN, CWC_OFF_SEL, CWC_OFF_AUTO, CWC_OFF_DBR, CWC_OFF_DBF};
    logic [7:0] msk [5] = '{CWC_MAIN_MASK, CWC_SEL_MASK, 8'h4F, CWC_DB_MASK, CWC_DB_MASK};
    logic [7:0] kept [5] = '{8'h00, 8'hF0, 8'h00, 8'h3F, 8'h3F};
    logic [7:0] en [3] = '{8'h08, 8'h04, 8'h01};
    int bt [3] = '{0, 1, 8};

    // 100 MHz clock
    always #5 hclk = ~hclk;
    // free-running fast oscillator pin, half the bus clock rate
    always @(posedge hclk) hfo <= ~hfo;

    cwc_top cwc_top_i (.hclk(hclk), .hresetn(hresetn), .power_on_reset_n(por_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(CWC_HSIZE_WORD),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .internal_fast_oscillator(hfo), .logic_cell_one_output(src[7]),
        .oscillator_unit_output(src[6]), .pulse_unit_one_output(src[2]),
        .pulse_unit_two_output(src[3]), .pulse_unit_three_output(src[4]),
        .pulse_unit_four_output(src[5]), .comparator_one_raw_output(src[1]),
        .comparator_two_raw_output(src[0]), .logic_cell_two_output(src[8]),
        .external_fault_input(flt), .waveform_output_a(wa), .waveform_output_a_oe(wa_oe),
        .waveform_output_b(wb), .waveform_output_b_oe(wb_oe));

    cwc_switch_model cwc_switch_model_i (.hclk(hclk), .a(wa), .a_oe(wa_oe), .b(wb),
        .b_oe(wb_oe), .pin_a(pin_a), .pin_b(pin_b), .shoot_cnt(shoot_cnt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // wait for hready at a rising edge, bounded
    task automatic rdy;
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 50) begin
                n_mismatch++;
                report_and_stop;
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= CWC_HTRANS_NONSEQ;
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rdy;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(hrdata, {24'h0, e});
    endtask
    // edge on pulse unit one: off pin falls, then on pin rises n or n+1 later
    task automatic edge_gap(input logic up, input int n);
        int i, g;
        i = 0;
        g = 0;
        src[2] <= up;
        while ((up ? pin_b : pin_a) !== 1'b0 && i < 40) begin
            @(posedge hclk);
            i++;
        end
        while ((up ? pin_a : pin_b) !== 1'b1 && g < 80) begin
            @(posedge hclk);
            g++;
        end
        chk(g, (g == n + 1) ? n + 1 : n);
        if (i >= 40 || g >= 80) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        for (k = 0; k < 5; k++) wr(off[k], 8'hFF);
        wr(8'h14, 8'hFF);
        for (k = 0; k < 5; k++) rd(off[k], msk[k]);
        rd(8'h14, 8'h00);
        hresetn <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (k = 0; k < 5; k++) rd(off[k], kept[k]);
        por_n <= 1'b0;
        cyc(2);
        por_n <= 1'b1;
        @(posedge hclk);
        rd(CWC_OFF_DBR, {2'b00, CWC_POR_DB});
    endtask
    task automatic t_select;
        wr(CWC_OFF_MAIN, 8'hE0);
        shoot = shoot_cnt;
        for (k = 0; k < 8; k++) begin
            wr(CWC_OFF_SEL, 8'(k));
            src[k] <= 1'b1;
            cyc(8);
            chk(pin_a, 1);
            src[k] <= 1'b0;
            cyc(8);
            chk(pin_b, 1);
        end
        wr(CWC_OFF_DBR, 8'd5);
        wr(CWC_OFF_DBF, 8'd2);
        wr(CWC_OFF_SEL, 8'h02);
        edge_gap(1'b1, 5);
        edge_gap(1'b0, 2);
        chk(shoot_cnt, shoot);
    endtask
    task automatic t_pol;
        wr(CWC_OFF_MAIN, 8'hF8);
        cyc(8);
        chk({pin_a, pin_b}, 2'b10);
        wr(CWC_OFF_MAIN, 8'h78);
        cyc(4);
        chk({wa_oe, wb_oe}, 2'b00);
        wr(CWC_OFF_MAIN, 8'hA0);
        cyc(8);
        chk({wa_oe, wb_oe}, 2'b10);
        wr(CWC_OFF_MAIN, 8'hE0);
    endtask
    // oscillator clock: each count lasts two hclk periods here,
    // so a count of N shows a gap of 2N-1 or 2N cycles
    task automatic t_clk;
        wr(CWC_OFF_MAIN, 8'hE1);
        wr(CWC_OFF_DBR, 8'd3);
        wr(CWC_OFF_DBF, 8'd2);
        cyc(4);
        edge_gap(1'b1, 2 * 3 - 1);
        edge_gap(1'b0, 2 * 2 - 1);
        wr(CWC_OFF_MAIN, 8'hE0);
    endtask
    task automatic t_shut;
        wr(CWC_OFF_SEL, 8'h72);
        wr(CWC_OFF_AUTO, 8'h02);
        flt <= 1'b0;
        cyc(8);
        chk({pin_a, wb_oe}, 2'b10);
        rd(CWC_OFF_AUTO, 8'h82);
        wr(CWC_OFF_AUTO, 8'h02);
        rd(CWC_OFF_AUTO, 8'h82);
        flt <= 1'b1;
        cyc(8);
        rd(CWC_OFF_AUTO, 8'h82);
        wr(CWC_OFF_AUTO, 8'h02);
        cyc(6);
        chk({pin_a, wb_oe}, 2'b10);
        src[2] <= 1'b1;
        cyc(12);
        chk({pin_a, wb_oe}, 2'b11);
        src[2] <= 1'b0;
        for (k = 0; k < 3; k++) begin
            wr(CWC_OFF_AUTO, 8'h40 | en[k]);
            src[bt[k]] <= 1'b1;
            cyc(6);
            rd(CWC_OFF_AUTO, 8'hC0 | en[k]);
            src[bt[k]] <= 1'b0;
            cyc(6);
            rd(CWC_OFF_AUTO, 8'h40 | en[k]);
        end
        // software shutdown: B forced low, A inactive with polarity applied
        wr(CWC_OFF_MAIN, 8'hF8);
        wr(CWC_OFF_SEL, 8'h82);
        wr(CWC_OFF_AUTO, 8'h80);
        cyc(6);
        chk({pin_a, pin_b, wb_oe}, 3'b101);
        rd(CWC_OFF_AUTO, 8'h80);
    endtask

    // main sequence
    initial begin
        cyc(2);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_select;
        t_pol;
        t_clk;
        t_shut;
        report_and_stop;
    end
endmodule // complementary_waveform_control_tb
